// [common/rfc_defs.svh]
// timing counts and reset values for the resonant feedback chain control
// assumes inclusion by bare name from package or design files
`ifndef RFC_DEFS_SVH
`define RFC_DEFS_SVH

// device clock rate in MHz (4 ns period)
`define RFC_MCLK_MHZ        250
// continuous feedback-below-burst time before restart, in ms
`define RFC_BURST_HOLD_MS   200
// hold time as a count of device clock cycles
`define RFC_BURST_HOLD_CYC  (`RFC_BURST_HOLD_MS * 1000 * `RFC_MCLK_MHZ)
// number of comparator inputs brought through synchronisers
`define RFC_NUM_CMP         7
// edges before synchronised comparator levels are real samples
`define RFC_SYNC_SETTLE     2'h2
// reset values
`define RFC_SYNC_RST        1'b0
`define RFC_RAMP_DIR_RST    1'b1
`define RFC_RAMP_ON_RST     1'b1
`define RFC_VCR_SHORT_RST   1'b1

`endif

// [common/rfc_pkg.sv]
// types shared by the resonant feedback chain control
// assumes rfc_defs.svh is on the include path
package rfc_pkg;

  // control sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SOFTSTART,
    ST_RUN,
    ST_HVOFF,
    ST_FAULT
  } rfc_state_t;

  // analog comparator results, one bit each
  typedef struct packed {
    logic gate_supply_low;   // regulated_gate_supply below lockout
    logic fb_below_ss;       // feedback_copy_level below soft-start level
    logic fb_below_burst;    // feedback_copy_level below burst_threshold
    logic ss_below_burst;    // soft-start level below burst_threshold
    logic vcr_above_high;    // resonant_sense_node above upper threshold
    logic vcr_below_low;     // resonant_sense_node below lower threshold
    logic vcr_above_cm;      // resonant_sense_node above common mode
  } rfc_cmp_t;

  // gate-on signals from the waveform generator
  typedef struct packed {
    logic hs_on;
    logic ls_on;
  } rfc_gate_t;

  // results handed to the waveform generator
  typedef struct packed {
    logic vcr_above_high;
    logic vcr_below_low;
    logic vcr_above_cm;
    logic hs_end;
    logic ls_end;
  } rfc_wave_t;

endpackage

// [hdl/rfc_feedback_chain.sv]
// resonant converter feedback chain control: supply fault, burst stop,
// external shutdown and restart, soft-start demand selection, burst
// threshold selection, compensation ramp direction and sense-node clamp
// assumes comparator levels arrive asynchronously from the analog front
// end and gate-on / capacitive-region signals come from logic on mclk_i
//
// Operation
// - gate supply below lockout during operation forces the fault state
// - feedback below burst threshold stops half-bridge switching
// - feedback below burst for over 200 ms: startup-off, then restart
// - start only when feedback is not below burst; held low never restarts
// - demand path takes the lower of feedback and selected second input
// - second input is soft-start until complete, analog supply afterwards
// - soft-start complete needs initiation, ramp above feedback, no capacitive
// - capacitive-region event clears soft-start complete, pulldown passes
// - soft-start charge is enable and not complete and not capacitive
// - demand takes higher of lower output and burst threshold, flags below
// - burst threshold forced to ground during soft start
// - sense node shorted to common mode while idle and before startup
// - compensation ramp always on, reverses when exactly one gate-on signal falls
// - sense node compared with upper, lower and common mode thresholds
// - high side ends above upper, low side ends below lower threshold
`timescale 1ns/100ps
`include "rfc_defs.svh"

module rfc_feedback_chain #(
  parameter int HOLD_CYCLES = `RFC_BURST_HOLD_CYC
) (
  // clock and reset
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  // asynchronous comparator levels from the analog front end
  input  wire logic               gate_supply_low_i,
  input  wire logic               fb_below_ss_i,
  input  wire logic               fb_below_burst_i,
  input  wire logic               ss_below_burst_i,
  input  wire logic               vcr_above_high_i,
  input  wire logic               vcr_below_low_i,
  input  wire logic               vcr_above_cm_i,
  // synchronous inputs from the waveform generator and sequencing
  input  wire logic               hs_on_i,
  input  wire logic               ls_on_i,
  input  wire logic               capacitive_region_flag_i,
  input  wire logic               start_enable_i,
  input  wire logic               fault_release_i,
  // demand path controls
  output logic                    softstart_enable_o,
  output logic                    softstart_complete_o,
  output logic                    softstart_charge_enable_o,
  output logic                    demand_sel_softstart_o,
  output logic                    lower_is_feedback_o,
  output logic                    burst_sel_ground_o,
  output logic                    feedback_below_burst_flag_o,
  // switching and sequencer status
  output logic                    switching_enable_o,
  output logic                    hv_startup_off_o,
  output logic                    fault_o,
  output rfc_pkg::rfc_state_t     state_o,
  // compensation ramp and sense node
  output logic                    ramp_on_o,
  output logic                    ramp_up_o,
  output logic                    vcr_short_o,
  // results to the waveform generator
  output rfc_pkg::rfc_wave_t      wave_o
);

  // whole module state
  typedef struct packed {
    rfc_pkg::rfc_state_t st;
    logic                ss_done;
    logic                ss_en;
    logic                ss_charge;
    logic                sel_ss;
    logic                lower_fb;
    logic                burst_gnd;
    logic                below_burst;
    logic                sw_en;
    logic                hvoff;
    logic                fault;
    logic                ramp_on;
    logic                ramp_dir;
    logic                hs_q;
    logic                ls_q;
    logic                vcr_short;
    logic [1:0]          settle;     // edges since reset, saturates
    rfc_pkg::rfc_wave_t  wave;
  } rfc_top_state_t;

  rfc_top_state_t   top_reg;
  rfc_top_state_t   top_next;
  // synchronised comparator levels and gate inputs
  rfc_pkg::rfc_cmp_t cmp_async;
  rfc_pkg::rfc_cmp_t cmp;
  rfc_pkg::rfc_gate_t gate;

  // decoded conditions shared by the two combinational processes
  logic              cmp_valid;
  logic              hold_expired;
  logic              hold_level;
  logic              ss_active;
  logic              lower_fb;
  logic              below_burst;
  logic              ss_done_next;
  logic              hs_fall;
  logic              ls_fall;

  // gather comparator levels for the synchroniser bank
  assign cmp_async = '{gate_supply_low: gate_supply_low_i,
                       fb_below_ss:     fb_below_ss_i,
                       fb_below_burst:  fb_below_burst_i,
                       ss_below_burst:  ss_below_burst_i,
                       vcr_above_high:  vcr_above_high_i,
                       vcr_below_low:   vcr_below_low_i,
                       vcr_above_cm:    vcr_above_cm_i};
  assign gate = '{hs_on: hs_on_i, ls_on: ls_on_i};

  // two-flop synchronisers on every comparator level
  // no comparator level is ever read before both flops
  rfc_sync #(
    .W ($bits(rfc_pkg::rfc_cmp_t))
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .async_i (cmp_async),
    .sync_o  (cmp)
  );

  // restart timer runs only while burst-stopped in normal operation
  assign hold_level = top_reg.below_burst && (top_reg.st == rfc_pkg::ST_RUN);

  rfc_persist #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_hold (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .level_i   (hold_level),
    .expired_o (hold_expired)
  );

  // demand path selection and burst comparison
  always_comb begin
    ss_active = (top_reg.st == rfc_pkg::ST_SOFTSTART) ||
                (top_reg.st == rfc_pkg::ST_RUN);
    // synchronised levels are real samples from the second edge on
    cmp_valid = (top_reg.settle == `RFC_SYNC_SETTLE);
    // soft-start complete: initiated, ramp above feedback, no capacitive
    ss_done_next = ss_active && !capacitive_region_flag_i &&
                   (top_reg.ss_done || cmp.fb_below_ss);
    // analog supply sits above feedback, so once complete feedback is lower
    lower_fb = top_reg.ss_done || cmp.fb_below_ss;
    // ground threshold never sees anything below it
    if (top_reg.st == rfc_pkg::ST_SOFTSTART) begin
      below_burst = 1'b0;
    end else if (lower_fb) begin
      below_burst = cmp.fb_below_burst;
    end else begin
      below_burst = cmp.ss_below_burst;
    end
    // gate-on falling edges, one cycle of history
    hs_fall = top_reg.hs_q && !gate.hs_on;
    ls_fall = top_reg.ls_q && !gate.ls_on;
  end

  // next state of the sequencer and all registered outputs
  always_comb begin
    top_next = top_reg;
    // sequencer
    unique case (top_reg.st)
      rfc_pkg::ST_IDLE: begin
        // feedback held low keeps the converter parked here; a low
        // supply only blocks the start; reset zeros still in the
        // synchronisers are not taken as a real comparator result
        if (cmp_valid && start_enable_i && !cmp.gate_supply_low &&
            !cmp.fb_below_burst) begin
          top_next.st = rfc_pkg::ST_SOFTSTART;
        end
      end
      rfc_pkg::ST_SOFTSTART: begin
        // a supply dip during the ramp is a fault, not a retry
        if (cmp.gate_supply_low) begin
          top_next.st = rfc_pkg::ST_FAULT;
        end else if (ss_done_next) begin
          top_next.st = rfc_pkg::ST_RUN;
        end
      end
      rfc_pkg::ST_RUN: begin
        // supply loss outranks the burst-stop restart
        if (cmp.gate_supply_low) begin
          top_next.st = rfc_pkg::ST_FAULT;
        end else if (hold_expired) begin
          top_next.st = rfc_pkg::ST_HVOFF;
        end
      end
      rfc_pkg::ST_HVOFF: begin
        // one cycle with startup off, then retry from idle
        top_next.st = rfc_pkg::ST_IDLE;
      end
      rfc_pkg::ST_FAULT: begin
        // protection sequencing outside decides when to leave
        // a release while the supply is still low is ignored
        if (fault_release_i && !cmp.gate_supply_low) begin
          top_next.st = rfc_pkg::ST_HVOFF;
        end
      end
      // an unused state code falls back to idle with the bridge off
      default: begin
        top_next.st = rfc_pkg::ST_IDLE;
      end
    endcase

    // count the edges the synchronisers need to hold real samples
    if (top_reg.settle != `RFC_SYNC_SETTLE) begin
      top_next.settle = top_reg.settle + 2'h1;
    end

    // soft-start control
    // complete stays set until a capacitive event or an exit from run
    top_next.ss_done   = ss_done_next;
    top_next.ss_en     = ss_active;
    top_next.ss_charge = ss_active && !ss_done_next &&
                         !capacitive_region_flag_i;
    top_next.sel_ss    = !ss_done_next;
    top_next.lower_fb  = lower_fb;
    top_next.burst_gnd = (top_reg.st == rfc_pkg::ST_SOFTSTART);
    top_next.below_burst = below_burst;

    // switching gate: burst stop and supply loss both halt the bridge
    top_next.sw_en = ss_active && !below_burst &&
                     !cmp.gate_supply_low;

    // status flags follow the state being entered
    top_next.hvoff = (top_next.st == rfc_pkg::ST_HVOFF);
    top_next.fault = (top_next.st == rfc_pkg::ST_FAULT);

    // clamp the sense node whenever the bridge is not switching
    top_next.vcr_short = !top_next.sw_en;

    // compensation ramp never stops, flips when exactly one gate-on signal falls
    top_next.ramp_on = 1'b1;
    top_next.hs_q    = gate.hs_on;
    top_next.ls_q    = gate.ls_on;
    // both falling together is a generator glitch; keep direction
    if (hs_fall ^ ls_fall) begin
      top_next.ramp_dir = !top_reg.ramp_dir;
    end

    // sense node comparisons and on-time ends for the waveform generator
    top_next.wave.vcr_above_high = cmp.vcr_above_high;
    top_next.wave.vcr_below_low  = cmp.vcr_below_low;
    top_next.wave.vcr_above_cm   = cmp.vcr_above_cm;
    // on-time ends use the live gate level so a stale compare cannot end the next phase
    top_next.wave.hs_end = gate.hs_on && cmp.vcr_above_high;
    top_next.wave.ls_end = gate.ls_on && cmp.vcr_below_low;
  end

  // state registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      top_reg <= '{st:          rfc_pkg::ST_IDLE,
                   ss_done:     1'b0,
                   ss_en:       1'b0,
                   ss_charge:   1'b0,
                   sel_ss:      1'b1,
                   lower_fb:    1'b0,
                   burst_gnd:   1'b0,
                   below_burst: 1'b0,
                   sw_en:       1'b0,
                   hvoff:       1'b0,
                   fault:       1'b0,
                   ramp_on:     `RFC_RAMP_ON_RST,
                   ramp_dir:    `RFC_RAMP_DIR_RST,
                   hs_q:        1'b0,
                   ls_q:        1'b0,
                   vcr_short:   `RFC_VCR_SHORT_RST,
                   settle:      2'h0,
                   wave:        '0};
    end else begin
      top_reg <= top_next;
    end
  end

  // outputs straight from the state register
  assign softstart_enable_o          = top_reg.ss_en;
  assign softstart_complete_o        = top_reg.ss_done;
  assign softstart_charge_enable_o   = top_reg.ss_charge;
  assign demand_sel_softstart_o      = top_reg.sel_ss;
  assign lower_is_feedback_o         = top_reg.lower_fb;
  assign burst_sel_ground_o          = top_reg.burst_gnd;
  assign feedback_below_burst_flag_o = top_reg.below_burst;
  assign switching_enable_o          = top_reg.sw_en;
  assign hv_startup_off_o            = top_reg.hvoff;
  assign fault_o                     = top_reg.fault;
  assign state_o                     = top_reg.st;
  assign ramp_on_o                   = top_reg.ramp_on;
  assign ramp_up_o                   = top_reg.ramp_dir;
  assign vcr_short_o                 = top_reg.vcr_short;
  assign wave_o                      = top_reg.wave;

endmodule

// [hdl/rfc_persist.sv]
// persistence timer: pulses once a level has held longer than HOLD_CYCLES
// assumes level_i is synchronous to mclk_i
`timescale 1ns/100ps
`include "rfc_defs.svh"

module rfc_persist #(
  parameter int HOLD_CYCLES = `RFC_BURST_HOLD_CYC
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // level and expiry pulse
  input  wire logic level_i,
  output logic      expired_o
);

  localparam int CNT_W = $clog2(HOLD_CYCLES + 1);
  localparam logic [CNT_W-1:0] HOLD = CNT_W'(HOLD_CYCLES);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             expired;
  } rfc_persist_state_t;

  rfc_persist_state_t tmr_reg;
  rfc_persist_state_t tmr_next;

  // count while the level holds, restart on any gap, restart from zero at expiry
  always_comb begin
    tmr_next         = tmr_reg;
    tmr_next.expired = 1'b0;
    if (!level_i) begin
      tmr_next.cnt = '0;
    end else if (tmr_reg.cnt == HOLD) begin
      tmr_next.expired = 1'b1;
      tmr_next.cnt     = '0;
    end else begin
      tmr_next.cnt = tmr_reg.cnt + CNT_W'(1);
    end
  end

  // state registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tmr_reg <= '{cnt: '0, expired: 1'b0};
    end else begin
      tmr_reg <= tmr_next;
    end
  end

  assign expired_o = tmr_reg.expired;

endmodule

// [hdl/rfc_sync.sv]
// two-flop synchroniser bank for asynchronous comparator levels
// assumes inputs may change at any time relative to mclk_i
`timescale 1ns/100ps
`include "rfc_defs.svh"

module rfc_sync #(
  parameter int W = `RFC_NUM_CMP
) (
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  // levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rfc_sync_state_t;

  rfc_sync_state_t sync_reg;
  rfc_sync_state_t sync_next;

  // first stage feeds only the second stage
  always_comb begin
    sync_next = sync_reg;
    for (int i = 0; i < W; i++) begin
      sync_next.s1[i] = async_i[i];
      sync_next.s2[i] = sync_reg.s1[i];
    end
  end

  // state registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_reg <= '{s1: {W{`RFC_SYNC_RST}}, s2: {W{`RFC_SYNC_RST}}};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg.s2;

endmodule

// [testbench/rfc_feedback_chain_bench.sv]
// self-checking bench for the feedback chain control
// assumes the monitor bind and the partner model are compiled alongside
`timescale 1ns/100ps
module rfc_feedback_chain_bench;
  localparam int HOLD = 20;
  logic mclk_i = 1'b0, rst_i = 1'b1;
  logic gsl = 0, fbss = 0, fbb = 0, cap = 0, start = 0, frel = 0, ssb = 0;
  logic hs, ls, vah, vbl, vcm, ss_en, done, charge, dsel, lif, bgnd, flag;
  logic sw_en, hvoff, fault, r_on, r_up, vshort;
  logic [3:0] half = 4'h3;
  rfc_pkg::rfc_state_t st;
  rfc_pkg::rfc_wave_t  wave;
  int n_errors = 0, total_checks = 0, cyc_n = 0, t0;

  // clock and cycle count
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc_n++;

  rfc_feedback_chain #(.HOLD_CYCLES(HOLD)) u_rfc_feedback_chain (
    .mclk_i(mclk_i), .rst_i(rst_i), .gate_supply_low_i(gsl), .fb_below_ss_i(fbss),
    .fb_below_burst_i(fbb), .ss_below_burst_i(ssb), .vcr_above_high_i(vah),
    .vcr_below_low_i(vbl), .vcr_above_cm_i(vcm), .hs_on_i(hs), .ls_on_i(ls),
    .capacitive_region_flag_i(cap), .start_enable_i(start), .fault_release_i(frel),
    .softstart_enable_o(ss_en), .softstart_complete_o(done),
    .softstart_charge_enable_o(charge), .demand_sel_softstart_o(dsel),
    .lower_is_feedback_o(lif), .burst_sel_ground_o(bgnd),
    .feedback_below_burst_flag_o(flag), .switching_enable_o(sw_en),
    .hv_startup_off_o(hvoff), .fault_o(fault), .state_o(st), .ramp_on_o(r_on),
    .ramp_up_o(r_up), .vcr_short_o(vshort), .wave_o(wave));

  rfc_partner u_rfc_partner (
    .mclk_i(mclk_i), .rst_i(rst_i), .sw_en_i(sw_en), .half_i(half),
    .hs_on_o(hs), .ls_on_o(ls), .vah_o(vah), .vbl_o(vbl), .vcm_o(vcm));

  function automatic logic charge_exp(input logic en, input logic dn, input logic c);
    return en & ~dn & ~c;
  endfunction

  task automatic end_sim;
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task automatic wait_st(input rfc_pkg::rfc_state_t s, input int lim);
    for (int i = 0; i < lim && st !== s; i++) @(negedge mclk_i);
    chk("state", s, st);
    if (st !== s) end_sim();
  endtask

  // main sequence
  initial begin
    int g;
    void'($urandom(32'hcea9a656));
    half = 4'h2 + 4'($urandom_range(3));
    g = 3 + $urandom_range(HOLD - 6);
    repeat (10) @(posedge mclk_i);
    @(negedge mclk_i) rst_i = 1'b0;
    chk("ramp_on", 1, r_on);
    chk("ramp_up", 1, r_up);
    chk("vcr_short", 1, vshort);
    chk("demand_sel", 1, dsel);
    // feedback held low never starts
    fbb = 1;
    start = 1;
    cyc(40);
    chk("state", rfc_pkg::ST_IDLE, st);
    chk("switching", 0, sw_en);
    fbb = 0;
    wait_st(rfc_pkg::ST_SOFTSTART, 10);
    cyc(3);
    chk("burst_ground", 1, bgnd);
    chk("ss_enable", 1, ss_en);
    chk("charge", charge_exp(1'b1, 1'b0, cap), charge);
    chk("complete", 0, done);
    chk("lower_fb", 0, lif);
    // low feedback ignored while ramping
    fbb = 1;
    cyc(5);
    chk("flag", 0, flag);
    chk("switching", 1, sw_en);
    fbb = 0;
    cyc(4);
    fbss = 1;
    wait_st(rfc_pkg::ST_RUN, 10);
    cyc(1);
    chk("complete", 1, done);
    chk("demand_sel", 0, dsel);
    chk("lower_fb", 1, lif);
    chk("charge", 0, charge);
    chk("vcr_short", 0, vshort);
    // capacitive event
    cyc(12);
    cap = 1;
    cyc(2);
    chk("complete", 0, done);
    chk("demand_sel", 1, dsel);
    chk("charge", 0, charge);
    // soft-start level falls below feedback and under the burst threshold
    fbss = 0;
    ssb = 1;
    cyc(4);
    chk("lower_fb", 0, lif);
    chk("flag", 1, flag);
    chk("switching", 0, sw_en);
    fbss = 1;
    ssb = 0;
    cap = 0;
    cyc(4);
    chk("complete", 1, done);
    // interrupted burst stop, then a full one
    fbb = 1;
    cyc(g);
    fbb = 0;
    cyc(5);
    chk("state", rfc_pkg::ST_RUN, st);
    fbb = 1;
    for (int i = 0; i < 10 && flag !== 1'b1; i++) @(negedge mclk_i);
    t0 = cyc_n;
    chk("flag", 1, flag);
    if (flag !== 1'b1) end_sim();
    cyc(2);
    chk("switching", 0, sw_en);
    wait_st(rfc_pkg::ST_HVOFF, HOLD + 10);
    chk("hold", 8'(HOLD + 2), 8'(cyc_n - t0));
    chk("hv_off", 1, hvoff);
    cyc(1);
    chk("hv_off", 0, hvoff);
    cyc(10);
    chk("state", rfc_pkg::ST_IDLE, st);
    fbb = 0;
    wait_st(rfc_pkg::ST_RUN, 20);
    // supply fault and release
    cyc(8);
    gsl = 1;
    wait_st(rfc_pkg::ST_FAULT, 6);
    cyc(1);
    chk("fault", 1, fault);
    chk("switching", 0, sw_en);
    frel = 1;
    cyc(4);
    chk("state", rfc_pkg::ST_FAULT, st);
    gsl = 0;
    wait_st(rfc_pkg::ST_HVOFF, 6);
    frel = 0;
    start = 0;
    wait_st(rfc_pkg::ST_IDLE, 4);
    end_sim();
  end
endmodule

// [testbench/rfc_feedback_chain_monitor.sv]
// checker for the feedback chain control, ports only
// assumes binding onto rfc_feedback_chain, one clock domain
`timescale 1ns/100ps
module rfc_feedback_chain_monitor #(
  parameter int HOLD_CYCLES = 20
) (
  // clock, reset and inputs
  input wire logic mclk_i, rst_i, gate_supply_low_i, fb_below_burst_i,
  input wire logic vcr_above_high_i, vcr_below_low_i, vcr_above_cm_i,
  input wire logic hs_on_i, ls_on_i, capacitive_region_flag_i,
  // outputs
  input wire logic softstart_complete_o, softstart_charge_enable_o,
  input wire logic demand_sel_softstart_o, feedback_below_burst_flag_o,
  input wire logic burst_sel_ground_o, lower_is_feedback_o,
  input wire logic switching_enable_o, hv_startup_off_o,
  input wire logic ramp_on_o, ramp_up_o, vcr_short_o,
  input wire rfc_pkg::rfc_state_t state_o,
  input wire rfc_pkg::rfc_wave_t  wave_o
);
  logic [1:0] up;
  logic       hs_d, ls_d, sfall;
  int         run_cnt;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // exactly one gate signal fell this cycle
  assign sfall = (hs_d & ~hs_on_i) ^ (ls_d & ~ls_on_i);

  // history, settle counter and burst-stop length
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      up      <= 2'h0;
      hs_d    <= 1'b0;
      ls_d    <= 1'b0;
      run_cnt <= 0;
    end else begin
      up      <= (up == 2'h3) ? up : up + 2'h1;
      hs_d    <= hs_on_i;
      ls_d    <= ls_on_i;
      run_cnt <= (state_o == rfc_pkg::ST_RUN && feedback_below_burst_flag_o) ? run_cnt + 1 : 0;
    end
  end

  ramp_always_on_a: assert property (ramp_on_o)
    else $error("ramp current off");
  ramp_direction_a: assert property (up == 2'h3 |-> $changed(ramp_up_o) == $past(sfall))
    else $error("ramp direction wrong");
  charge_enable_a: assert property (softstart_charge_enable_o |->
    !softstart_complete_o && !$past(capacitive_region_flag_i))
    else $error("soft-start charge enabled wrongly");
  demand_select_a: assert property (demand_sel_softstart_o != softstart_complete_o)
    else $error("demand select disagrees with complete");
  supply_fault_a: assert property ((state_o == rfc_pkg::ST_RUN && gate_supply_low_i)
    ##1 gate_supply_low_i [*2] |=> state_o == rfc_pkg::ST_FAULT)
    else $error("supply low without fault");
  start_refused_a: assert property ((state_o == rfc_pkg::ST_IDLE && fb_below_burst_i) [*3]
    |=> state_o != rfc_pkg::ST_SOFTSTART)
    else $error("start while feedback low");
  burst_stop_a: assert property ((state_o == rfc_pkg::ST_RUN && lower_is_feedback_o &&
    fb_below_burst_i) [*5] |-> !switching_enable_o)
    else $error("switching while below burst");
  softstart_ground_a: assert property ((state_o == rfc_pkg::ST_SOFTSTART) [*2] |->
    burst_sel_ground_o && !feedback_below_burst_flag_o)
    else $error("burst active in soft start");
  restart_hold_a: assert property (run_cnt <= HOLD_CYCLES + 2)
    else $error("burst stop held too long");
  startup_off_exit_a: assert property (state_o == rfc_pkg::ST_HVOFF |->
    hv_startup_off_o ##1 (state_o == rfc_pkg::ST_IDLE && !hv_startup_off_o))
    else $error("startup-off exit wrong");
  idle_clamp_a: assert property ((state_o == rfc_pkg::ST_IDLE) [*2] |-> vcr_short_o)
    else $error("sense node not clamped");
  sense_compare_a: assert property (up == 2'h3 |-> wave_o[4:2] ===
    {$past(vcr_above_high_i, 3), $past(vcr_below_low_i, 3), $past(vcr_above_cm_i, 3)})
    else $error("comparator results wrong");
  gate_end_a: assert property (up == 2'h3 |-> wave_o[1:0] ===
    {$past(hs_on_i) & $past(vcr_above_high_i, 3), $past(ls_on_i) & $past(vcr_below_low_i, 3)})
    else $error("gate end wrong");
endmodule

bind rfc_feedback_chain rfc_feedback_chain_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_mon (
  .mclk_i, .rst_i, .gate_supply_low_i, .fb_below_burst_i, .vcr_above_high_i,
  .vcr_below_low_i, .vcr_above_cm_i, .hs_on_i, .ls_on_i, .capacitive_region_flag_i,
  .softstart_complete_o, .softstart_charge_enable_o, .demand_sel_softstart_o,
  .feedback_below_burst_flag_o, .burst_sel_ground_o, .lower_is_feedback_o,
  .switching_enable_o, .hv_startup_off_o, .ramp_on_o, .ramp_up_o, .vcr_short_o,
  .state_o, .wave_o);

// [testbench/rfc_partner.sv]
// model of the waveform generator gate timing and sense-node comparators
// assumes sw_en_i comes from the control on mclk_i
`timescale 1ns/100ps
module rfc_partner (
  // clock, reset and control
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       sw_en_i,
  input  wire logic [3:0] half_i,
  // gate-on and comparator levels
  output logic            hs_on_o,
  output logic            ls_on_o,
  output logic            vah_o,
  output logic            vbl_o,
  output logic            vcm_o
);
  logic [1:0] ph;
  logic [3:0] cnt;

  // high on, dead, low on, dead; stops when switching stops
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ph  <= 2'h0;
      cnt <= 4'h0;
    end else if (!sw_en_i) begin
      ph  <= 2'h0;
      cnt <= 4'h0;
    end else if (cnt >= half_i) begin
      cnt <= 4'h0;
      ph  <= ph + 2'h1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end

  // node crosses a threshold at the end of each on-time
  assign hs_on_o = sw_en_i && ph == 2'h0;
  assign ls_on_o = sw_en_i && ph == 2'h2;
  assign vah_o   = hs_on_o && cnt == half_i;
  assign vbl_o   = ls_on_o && cnt == half_i;
  assign vcm_o   = sw_en_i && !ph[1];
endmodule
